// ===== core/tdf_defs.svh
/*
 * Constants of the transmit descriptor field handler: register offsets,
 * field positions inside a fetched descriptor, and reset values.
 * Assumes inclusion by bare name from the package.
 */
`ifndef TDF_DEFS_SVH
`define TDF_DEFS_SVH

// Register offsets on the plain register port
`define TDF_REG_CTRL        8'h00
`define TDF_REG_TABLE_BASE  8'h04
`define TDF_REG_STATUS      8'h08
`define TDF_REG_UNPROV      8'h0c

// Control and status bit positions
`define TDF_CTRL_ENABLE     0
`define TDF_CTRL_FLUSH      1
`define TDF_STAT_BUSY       0
`define TDF_STAT_HI_PEND    1
`define TDF_STAT_LO_PEND    2
`define TDF_STAT_ZERO_ERR   3

// Descriptor geometry
`define TDF_DESC_WORDS      2'h3
`define TDF_IDX_W           15
`define TDF_CHAN_W          10

// Control word (word 1) field positions
`define TDF_W1_CNT_LSB      0
`define TDF_W1_PRI          16
`define TDF_W1_ABORT        17
`define TDF_W1_NOTIFY       18
`define TDF_W1_LAST         19
`define TDF_W1_MORE         20
`define TDF_W1_CHAN_LSB     22

// Reset values
`define TDF_RST_TABLE_BASE  32'h0000_0000

`endif

// ===== core/tdf_pkg.sv
/*
 * Types of the transmit descriptor field handler.
 * Assumes tdf_defs.svh is on the include path.
 */
package tdf_pkg;
`include "tdf_defs.svh"

    // One descriptor as held in a priority queue
    typedef struct packed {
        logic                   dead;
        logic                   link_valid_flag;
        logic [`TDF_IDX_W-1:0]  dev_next;
        logic [`TDF_IDX_W-1:0]  descriptor_index;
        logic [`TDF_CHAN_W-1:0] channel_code;
        logic                   abort_flag;
        logic                   notify_on_done_flag;
        logic                   chain_last_flag;
        logic                   more_fragments_flag;
        logic                   priority_flag;
        logic [15:0]            byte_count;
        logic [31:0]            buf_addr;
    } tdf_desc_type;

    // One outgoing data word
    typedef struct packed {
        logic [31:0]            data;
        logic [2:0]             nbytes;
        logic [`TDF_CHAN_W-1:0] channel_code;
        logic                   eop;
        logic                   abort;
    } tdf_beat_type;

    typedef enum logic [2:0] {
        S_IDLE, S_DESC, S_PUSH, S_DATA, S_OUT, S_DONE, S_UNPROV
    } tdf_state_type;

endpackage

// ===== core/tdf_engine.sv
/*
 * Transmit descriptor engine: fetches descriptors from host memory,
 * sorts them into a high and a low priority queue, reads each buffer
 * word by word and streams it out, and returns finished indexes.
 * Assumes a single-clock host memory port with one outstanding read
 * and a plain register port driven from the same clock.
 */
// Notes on behaviour
// - Buffer start address is always valid; data is fetched from it.
// - Byte count gives exact bytes sent; zero count is illegal.
// - Priority flag high queues high, low queues low.
// - Low queue never starts while the high queue holds packets.
// - Abort flag: send all buffer data, then abort the packet.
// - Notify flag pulses done_interrupt once the buffer is fully read.
// - Notify flag also flushes the free-queue cache; clear means neither.
// - Chain-last ends the list; host next pointer followed only otherwise.
// - Channel code selects the transmit channel of the data.
// - Link-valid flag marks the device next pointer valid.
// - Device links same channel and priority; returns head on unprovision.
// - Descriptor address is table base plus sixteen times the index.
// - More-fragments high: part of a packet; low: whole or final part.
`timescale 1ns/1ps
module tdf_engine
    import tdf_pkg::*;
#(
    parameter int QD = 4
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // Ready descriptor indexes from the host side queue logic
    input  wire logic                   rdy_valid,
    input  wire logic [`TDF_IDX_W-1:0]  rdy_index,
    output logic                        rdy_ready,
    // Host memory read master
    output logic                        mem_req,
    output logic      [31:0]            mem_addr,
    input  wire logic                   mem_rvalid,
    input  wire logic [31:0]            mem_rdata,
    // Outgoing data stream
    output logic                        tx_valid,
    output tdf_beat_type                tx_beat,
    input  wire logic                   tx_ready,
    // Returned indexes and events
    output logic                        free_valid,
    output logic      [`TDF_IDX_W-1:0]  free_index,
    output logic                        free_returned,
    output logic                        done_interrupt,
    output logic                        fq_flush
);
    localparam int PW = $clog2(QD);

    tdf_state_type          state_q;
    tdf_desc_type           rec_q [2][QD];
    logic [PW-1:0]          rd_q  [2];
    logic [PW-1:0]          wr_q  [2];
    logic [PW:0]            cnt_q [2];
    logic [31:0]            dw_q  [3];
    logic [1:0]             wcnt_q;
    logic                   wait_q;
    logic                   enable_q;
    logic                   flush_req_q;
    logic [31:0]            base_q;
    logic                   zero_err_q;
    logic                   unprov_pend_q;
    logic [`TDF_CHAN_W-1:0] unprov_chan_q;
    logic [`TDF_IDX_W+1:0]  unprov_res_q;
    logic                   chain_pend_q;
    logic [`TDF_IDX_W-1:0]  chain_next_q;
    logic [`TDF_IDX_W-1:0]  fetch_idx_q;
    tdf_desc_type           cur_q;
    logic [31:0]            addr_q;
    logic [15:0]            rem_q;

    logic                   space;
    logic                   sel_hi;
    tdf_desc_type           head;
    tdf_desc_type           new_rec;
    logic                   push;
    logic                   pop;
    logic                   take_rdy;
    logic                   start_fetch;
    logic                   is_last_word;
    logic [2:0]             nb;
    logic                   hit_found;
    logic [`TDF_IDX_W-1:0]  hit_index;
    logic                   stat_clr;

    // Queue head selection; high queue always wins
    assign sel_hi = (cnt_q[1] != '0);
    assign head   = rec_q[sel_hi][rd_q[sel_hi]];
    assign space  = (cnt_q[0] != QD[PW:0]) && (cnt_q[1] != QD[PW:0]);

    // Decode of the fetched control word
    always_comb begin
        new_rec                     = '0;
        new_rec.buf_addr            = dw_q[0];
        new_rec.byte_count          = dw_q[1][`TDF_W1_CNT_LSB +: 16];
        new_rec.priority_flag       = dw_q[1][`TDF_W1_PRI];
        new_rec.abort_flag          = dw_q[1][`TDF_W1_ABORT];
        new_rec.notify_on_done_flag = dw_q[1][`TDF_W1_NOTIFY];
        new_rec.chain_last_flag     = dw_q[1][`TDF_W1_LAST];
        new_rec.more_fragments_flag = dw_q[1][`TDF_W1_MORE];
        new_rec.channel_code        = dw_q[1][`TDF_W1_CHAN_LSB +: 10];
        new_rec.descriptor_index    = fetch_idx_q;
        new_rec.link_valid_flag     = 1'b0;
    end

    // Sequencer decisions
    assign take_rdy    = (state_q == S_IDLE) && !unprov_pend_q
                         && !chain_pend_q && enable_q && space;
    assign rdy_ready   = take_rdy;
    assign start_fetch = (take_rdy && rdy_valid)
                         || ((state_q == S_IDLE) && !unprov_pend_q
                             && chain_pend_q && space);
    assign push        = (state_q == S_PUSH);
    assign pop         = (state_q == S_IDLE) && !unprov_pend_q
                         && !start_fetch && enable_q
                         && (cnt_q[0] != '0 || cnt_q[1] != '0);
    assign is_last_word = (rem_q <= 16'h0004);
    assign nb = is_last_word ? rem_q[2:0] : 3'h4;

    // Oldest live entry of the channel being removed, high queue searched first
    always_comb begin
        logic [PW-1:0] pos;
        pos       = '0;
        hit_found = 1'b0;
        hit_index = '0;
        for (int q = 1; q >= 0; q--) begin
            for (int i = 0; i < QD; i++) begin
                pos = rd_q[q] + i[PW-1:0];
                if (i < int'(cnt_q[q]) && !rec_q[q][pos].dead && !hit_found
                    && rec_q[q][pos].channel_code == unprov_chan_q) begin
                    hit_found = 1'b1;
                    hit_index = rec_q[q][pos].descriptor_index;
                end
            end
        end
    end

    // Priority queues with same-channel linking
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int q = 0; q < 2; q++) begin
                rd_q[q]  <= '0;
                wr_q[q]  <= '0;
                cnt_q[q] <= '0;
                for (int i = 0; i < QD; i++) begin
                    rec_q[q][i] <= '0;
                end
            end
        end else begin
            if (push) begin
                for (int q = 0; q < 2; q++) begin
                    if (new_rec.priority_flag == q[0]) begin
                        // Youngest same-channel entry gets the link
                        for (int i = 0; i < QD; i++) begin
                            if (i < int'(cnt_q[q])
                                && rec_q[q][rd_q[q] + i[PW-1:0]].channel_code
                                   == new_rec.channel_code
                                && !rec_q[q][rd_q[q] + i[PW-1:0]].dead
                                && !rec_q[q][rd_q[q] + i[PW-1:0]]
                                    .link_valid_flag) begin
                                rec_q[q][rd_q[q] + i[PW-1:0]].dev_next
                                    <= fetch_idx_q;
                                rec_q[q][rd_q[q] + i[PW-1:0]].link_valid_flag
                                    <= 1'b1;
                            end
                        end
                        rec_q[q][wr_q[q]] <= new_rec;
                        wr_q[q]  <= wr_q[q] + 1'b1;
                    end
                end
            end
            if (pop) begin
                rd_q[sel_hi] <= rd_q[sel_hi] + 1'b1;
            end
            for (int q = 0; q < 2; q++) begin
                cnt_q[q] <= cnt_q[q]
                    + (PW+1)'(push && new_rec.priority_flag == q[0])
                    - (PW+1)'(pop && sel_hi == q[0]);
            end
            // Removal marks every queued entry of the channel dead
            if (state_q == S_UNPROV) begin
                for (int q = 0; q < 2; q++) begin
                    for (int i = 0; i < QD; i++) begin
                        if (rec_q[q][i].channel_code == unprov_chan_q) begin
                            rec_q[q][i].dead <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Main sequencer and memory reads
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q      <= S_IDLE;
            wcnt_q       <= '0;
            wait_q       <= 1'b0;
            mem_req      <= 1'b0;
            mem_addr     <= '0;
            fetch_idx_q  <= '0;
            chain_pend_q <= 1'b0;
            chain_next_q <= '0;
            cur_q        <= '0;
            addr_q       <= '0;
            rem_q        <= '0;
            tx_valid     <= 1'b0;
            tx_beat      <= '0;
            for (int k = 0; k < 3; k++) begin
                dw_q[k] <= '0;
            end
        end else begin
            mem_req <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (unprov_pend_q) begin
                        state_q <= S_UNPROV;
                    end else if (start_fetch) begin
                        fetch_idx_q  <= chain_pend_q ? chain_next_q
                                                     : rdy_index;
                        chain_pend_q <= 1'b0;
                        wcnt_q       <= '0;
                        state_q      <= S_DESC;
                    end else if (pop && !head.dead) begin
                        cur_q   <= head;
                        addr_q  <= head.buf_addr;
                        rem_q   <= head.byte_count;
                        state_q <= (head.byte_count == '0) ? S_DONE
                                                           : S_DATA;
                    end
                end
                S_DESC: begin
                    // All control words land before any data read
                    if (!wait_q) begin
                        mem_req  <= 1'b1;
                        mem_addr <= base_q
                            + {13'h0, fetch_idx_q, 4'h0}
                            + {28'h0, wcnt_q, 2'h0};
                        wait_q   <= 1'b1;
                    end else if (mem_rvalid) begin
                        dw_q[wcnt_q] <= mem_rdata;
                        wait_q       <= 1'b0;
                        if (wcnt_q == `TDF_DESC_WORDS - 2'h1) begin
                            state_q <= S_PUSH;
                        end
                        wcnt_q <= wcnt_q + 2'h1;
                    end
                end
                S_PUSH: begin
                    // Host next pointer only counts before chain end
                    chain_pend_q <= !new_rec.chain_last_flag;
                    chain_next_q <= dw_q[2][`TDF_IDX_W-1:0];
                    state_q      <= S_IDLE;
                end
                S_DATA: begin
                    if (!wait_q) begin
                        mem_req  <= 1'b1;
                        mem_addr <= addr_q;
                        wait_q   <= 1'b1;
                    end else if (mem_rvalid) begin
                        wait_q               <= 1'b0;
                        tx_valid             <= 1'b1;
                        tx_beat.data         <= mem_rdata;
                        tx_beat.nbytes       <= nb;
                        tx_beat.channel_code <= cur_q.channel_code;
                        // Packet ends on final word unless more follows
                        tx_beat.eop   <= is_last_word
                            && !cur_q.more_fragments_flag;
                        tx_beat.abort <= is_last_word
                            && cur_q.abort_flag;
                        state_q       <= S_OUT;
                    end
                end
                S_OUT: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        rem_q    <= rem_q - {13'h0, nb};
                        addr_q   <= addr_q + 32'h4;
                        state_q  <= is_last_word ? S_DONE : S_DATA;
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                S_UNPROV: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Completion events: interrupt at last read, index return after
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_interrupt <= 1'b0;
            fq_flush       <= 1'b0;
            free_valid     <= 1'b0;
            free_index     <= '0;
            free_returned  <= 1'b0;
        end else begin
            done_interrupt <= (state_q == S_DATA) && wait_q && mem_rvalid
                && is_last_word && cur_q.notify_on_done_flag;
            // Notify also empties the free cache so the index goes out now
            fq_flush   <= ((state_q == S_DONE)
                && cur_q.notify_on_done_flag) || flush_req_q;
            free_valid <= (state_q == S_DONE)
                || ((state_q == S_UNPROV) && hit_found);
            free_index <= (state_q == S_UNPROV) ? hit_index
                                                : cur_q.descriptor_index;
            free_returned <= (state_q == S_UNPROV);
        end
    end

    assign stat_clr = reg_wr && (reg_addr == `TDF_REG_STATUS)
                      && reg_wdata[`TDF_STAT_ZERO_ERR];

    // Register writes; flush bit clears itself after one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_q      <= 1'b0;
            flush_req_q   <= 1'b0;
            base_q        <= `TDF_RST_TABLE_BASE;
            zero_err_q    <= 1'b0;
            unprov_pend_q <= 1'b0;
            unprov_chan_q <= '0;
            unprov_res_q  <= '0;
        end else begin
            flush_req_q <= reg_wr && (reg_addr == `TDF_REG_CTRL)
                           && reg_wdata[`TDF_CTRL_FLUSH];
            if (reg_wr && reg_addr == `TDF_REG_CTRL) begin
                enable_q <= reg_wdata[`TDF_CTRL_ENABLE];
            end
            if (reg_wr && reg_addr == `TDF_REG_TABLE_BASE) begin
                base_q <= {reg_wdata[31:4], 4'h0};
            end
            // A zero count seen in the same cycle as the clear wins
            if (state_q == S_IDLE && pop && !head.dead
                && head.byte_count == '0) begin
                zero_err_q <= 1'b1;
            end else if (stat_clr) begin
                zero_err_q <= 1'b0;
            end
            if (reg_wr && reg_addr == `TDF_REG_UNPROV) begin
                unprov_pend_q <= 1'b1;
                unprov_chan_q <= reg_wdata[`TDF_CHAN_W-1:0];
            end else if (state_q == S_UNPROV) begin
                unprov_pend_q <= 1'b0;
                unprov_res_q  <= {hit_found, 1'b0, hit_index};
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `TDF_REG_CTRL:       reg_rdata <= {31'h0, enable_q};
                `TDF_REG_TABLE_BASE: reg_rdata <= base_q;
                `TDF_REG_STATUS:     reg_rdata <= {28'h0, zero_err_q,
                    cnt_q[0] != '0, cnt_q[1] != '0, state_q != S_IDLE};
                `TDF_REG_UNPROV:     reg_rdata <= {15'h0, unprov_res_q};
                default:             reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ===== dv/tdf_engine_properties.sv
/* Port checker of the transmit descriptor engine.
   Assumes it is bound onto tdf_engine; one clock, async reset. */
`timescale 1ns/1ps
module tdf_engine_properties
    import tdf_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst,
    input wire logic         rdy_valid,
    input wire logic         rdy_ready,
    input wire logic         mem_req,
    input wire logic [31:0]  mem_addr,
    input wire logic         mem_rvalid,
    input wire logic         tx_valid,
    input wire tdf_beat_type tx_beat,
    input wire logic         tx_ready,
    input wire logic         done_interrupt,
    input wire logic         fq_flush
);
    logic outst_q;
    // One read in flight, else words reorder
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            outst_q <= 1'b0;
        else if (mem_req)
            outst_q <= 1'b1;
        else if (mem_rvalid)
            outst_q <= 1'b0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    one_read_a: assert property (
        mem_req |-> !outst_q) else $error("read overlap");
    fetch_start_a: assert property (
        rdy_valid && rdy_ready |-> ##[1:2] (mem_req && mem_addr[3:0] == 4'h0))
        else $error("bad fetch");
    take_gap_a: assert property (
        rdy_valid && rdy_ready |=> !rdy_ready [*3])
        else $error("early take");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
        else $error("beat not held");
    tx_cause_a: assert property (
        $rose(tx_valid) |-> $past(mem_rvalid)) else $error("beat without data");
    beat_size_a: assert property (
        tx_valid |-> tx_beat.nbytes inside {[1:4]}) else $error("bad byte count");
    abort_end_a: assert property (
        tx_valid && tx_beat.abort |-> tx_beat.eop) else $error("abort not at end");
    done_cause_a: assert property (
        done_interrupt |-> $past(mem_rvalid)) else $error("done without read");
    done_pulse_a: assert property (
        done_interrupt |=> !done_interrupt) else $error("done not a pulse");
    flush_pulse_a: assert property (
        fq_flush |=> !fq_flush) else $error("flush not a pulse");
    cover property (done_interrupt);
    cover property (tx_valid && tx_beat.abort);
    cover property (tx_valid && !tx_ready);
endmodule

bind tdf_engine tdf_engine_properties u_props (.clock(clock), .rst(rst),
    .rdy_valid(rdy_valid), .rdy_ready(rdy_ready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .tx_valid(tx_valid),
    .tx_beat(tx_beat), .tx_ready(tx_ready),
    .done_interrupt(done_interrupt), .fq_flush(fq_flush));

// ===== dv/tdf_host_mem.sv
/* Host memory model: word reads, answered after one or three cycles.
   Assumes the bench fills words[] with descriptors before offering. */
`timescale 1ns/1ps
module tdf_host_mem (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata
);
    logic [31:0] words [logic [31:0]];
    logic [31:0] addr_q;
    logic [1:0]  wait_q;
    logic        busy_q;
    logic        slow_q;
    // Latency alternates; data toggles between answers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            slow_q <= 1'b0;
            wait_q <= 2'h0;
            addr_q <= 32'h0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req) begin
                busy_q <= 1'b1;
                addr_q <= mem_addr;
                wait_q <= slow_q ? 2'h2 : 2'h0;
                slow_q <= ~slow_q;
            end else if (busy_q && wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                mem_rvalid <= 1'b1;
                // Unlisted words are buffer data: an address pattern
                mem_rdata <= words.exists(addr_q) ? words[addr_q] :
                             {addr_q[15:0] ^ 16'h5a5a, addr_q[15:0]};
            end
        end
    end
endmodule

// ===== dv/test_tdf_engine.sv
/* Self-checking bench of the transmit descriptor engine.
   Assumes the host memory model and the bound port checker. */
`timescale 1ns/1ps
module test_tdf_engine;
    import tdf_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_1000;
    logic clock, rst, reg_wr, reg_rd, rdy_valid, rdy_ready, tx_ready;
    logic mem_req, mem_rvalid, tx_valid, free_valid, free_returned;
    logic done_interrupt, fq_flush;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_rdata, rd;
    logic [14:0] rdy_index, free_index;
    tdf_beat_type tx_beat;
    tdf_beat_type got[$];
    logic [15:0] freed[$];
    int bad_count, total_checks, n_done, n_flush, pos;

    tdf_engine DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rdy_valid(rdy_valid), .rdy_index(rdy_index),
        .rdy_ready(rdy_ready), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
        .tx_beat(tx_beat), .tx_ready(tx_ready), .free_valid(free_valid),
        .free_index(free_index), .free_returned(free_returned),
        .done_interrupt(done_interrupt), .fq_flush(fq_flush));
    tdf_host_mem MEM (.clock(clock), .rst(rst), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Sink stalls every other cycle; records beats, frees and pulses
    always @(posedge clock) begin
        tx_ready <= ~tx_ready & ~rst;
        if (tx_valid && tx_ready) got.push_back(tx_beat);
        if (free_valid) freed.push_back({free_returned, free_index});
        n_done += int'(done_interrupt === 1'b1);
        n_flush += int'(fq_flush === 1'b1);
    end

    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // f is {more, last, notify, abort, priority}
    task automatic put(input int idx, input logic [31:0] b, input int cnt,
                       input logic [4:0] f, input logic [9:0] ch, input int nx);
        MEM.words[BASE + 16 * idx] = b;
        MEM.words[BASE + 16 * idx + 4] = {ch, 1'b0, f, cnt[15:0]};
        MEM.words[BASE + 16 * idx + 8] = {17'h0, nx[14:0]};
    endtask
    task automatic offer(input int idx);
        int i;
        @(posedge clock);
        rdy_valid <= 1'b1;
        rdy_index <= idx[14:0];
        @(negedge clock);
        for (i = 0; i < 400 && rdy_ready !== 1'b1; i++) @(negedge clock);
        if (i == 400) begin
            bad_count++;
            wrap_up;
        end
        @(posedge clock);
        rdy_valid <= 1'b0;
    endtask
    task automatic wait_free(input int n);
        for (int i = 0; freed.size() < n; i++) begin
            if (i == 3000) begin
                bad_count++;
                wrap_up;
            end
            @(posedge clock);
        end
    endtask
    // Beats of one buffer, low bytes only on the short last word
    task automatic exp_buf(input logic [31:0] b, input int cnt,
                           input logic [9:0] ch, input logic e, input logic ab);
        tdf_beat_type g, x;
        logic [31:0] m, a;
        for (int r = cnt; r > 0; r -= 4) begin
            a = b + cnt - r;
            m = 32'hffff_ffff >> (8 * (r > 4 ? 0 : 4 - r));
            g = pos < got.size() ? got[pos] : 'x;
            g.data &= m;
            x = {{a[15:0] ^ 16'h5a5a, a[15:0]} & m, 3'(r > 4 ? 4 : r), ch,
                 e & (r <= 4), ab & (r <= 4)};
            chk(64'(g), 64'(x));
            pos++;
        end
    endtask

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, rdy_valid} = 3'h0;
        {reg_addr, reg_wdata, rdy_index} = '0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        reg_read(`TDF_REG_TABLE_BASE);
        chk(rd, `TDF_RST_TABLE_BASE);
        reg_read(8'h20);
        chk(rd, 32'h0);
        reg_write(`TDF_REG_TABLE_BASE, BASE);
        reg_read(`TDF_REG_TABLE_BASE);
        chk(rd, BASE);
        reg_write(`TDF_REG_CTRL, 32'h3);
        put(1, 32'h2000, 6, 5'b01000, 10'h005, 0);
        put(2, 32'h3000, 4, 5'b01111, 10'h009, 0);
        put(3, 32'h4000, 3, 5'b10000, 10'h00c, 4);
        put(4, 32'h5000, 5, 5'b01000, 10'h00c, 0);
        offer(1);
        offer(2);
        offer(3);
        wait_free(4);
        exp_buf(32'h3000, 4, 10'h009, 1'b1, 1'b1);
        exp_buf(32'h2000, 6, 10'h005, 1'b1, 1'b0);
        exp_buf(32'h4000, 3, 10'h00c, 1'b0, 1'b0);
        exp_buf(32'h5000, 5, 10'h00c, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++)
            chk(freed[k], k < 2 ? 2 - k : k + 1);
        chk(n_done, 1);
        chk(n_flush, 2);
        put(5, 32'h6000, 0, 5'b01000, 10'h001, 0);
        offer(5);
        wait_free(5);
        chk(freed[4], 16'h0005);
        reg_read(`TDF_REG_STATUS);
        chk(rd[3], 1'b1);
        reg_write(`TDF_REG_STATUS, 32'h8);
        reg_read(`TDF_REG_STATUS);
        chk(rd[3], 1'b0);
        put(6, 32'h7000, 8, 5'b01000, 10'h011, 0);
        offer(6);
        reg_write(`TDF_REG_UNPROV, 32'h11);
        wait_free(6);
        reg_read(`TDF_REG_UNPROV);
        chk({freed[5], rd}, 48'h8006_0001_0006);
        wrap_up;
    end
endmodule
